// [rtl/wkd_pattern_crc.sv]
module wkd_pattern_crc
  import wkd_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic [7:0] rx_data,
  input wire logic seed_one,
  input wire logic [127:0] mask,
  input wire logic [15:0] crc_ref,
  input wire logic [7:0] offset,
  output logic match
);
  logic [15:0] crc_r, crc_nxt;
  logic [10:0] pos_r, pos_nxt;
  logic match_r, match_nxt;
  logic [10:0] cur_pos;
  logic [10:0] rel;
  logic [15:0] crc_in;

  // one byte of msb-first crc16
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0} ^ (fb ? WKD_CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  // masked crc from the pattern offset, compare at frame end
  always_comb begin
    cur_pos = rx_sof ? 11'h000 : pos_r;
    rel = cur_pos - {3'h0, offset};
    crc_in = rx_sof ? (seed_one ? WKD_CRC_SEED_ONE : WKD_CRC_SEED_ZERO) : crc_r; // [R1]
    crc_nxt = crc_r;
    pos_nxt = pos_r;
    match_nxt = 1'b0;
    if (rx_valid) begin
      crc_nxt = crc_in;
      if (cur_pos >= {3'h0, offset} && rel < 11'h080 && mask[rel[6:0]]) begin
        crc_nxt = crc_step(crc_in, rx_data); // [R15]
      end
      if (cur_pos != 11'h7FF) begin
        pos_nxt = cur_pos + 11'h001;
      end
      match_nxt = rx_eof && (crc_nxt == crc_ref); // [R15]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      crc_r <= WKD_CRC_SEED_ZERO;
      pos_r <= 11'h000;
      match_r <= 1'b0;
    end else begin
      crc_r <= crc_nxt;
      pos_r <= pos_nxt;
      match_r <= match_nxt;
    end
  end

  assign match = match_r;
endmodule

// [rtl/wkd_pkg.sv]
// Function
// R1: The crc seed select bit starts each pattern crc at 0000h when clear and at FFFFh when set.
// R2: Each of the five pattern enables decides whether a match on that pattern counts at all.
// R3: With link down detect enabled, a link going from up to down sets the link change flag.
// R4: With link up detect enabled, a link going from down to up sets the link change flag.
// R5: With wake frame enable set, a frame matching an enabled pattern raises pm event status.
// R6: With remote wake enable set, a remote wake packet raises pm event status; its reset value is pm and wol both on.
// R7: With link change wake enable set, a link change event raises pm event status.
// R8: A frame matching an enabled pattern sets the wake frame seen flag.
// R9: A received remote wake packet sets the remote wake packet seen flag.
// R10: A detected link change event sets the link change seen flag.
// R11: Each of the three flags clears on a written one or on power-up reset; a written zero does nothing.
// R12: The three flags ignore hardware and software reset and only power-up reset clears them.
// R13: The pattern store holds five patterns of five words: four mask words then crc16 in 31:16 and offset in 7:0.
// R14: The data port walks an internal word pointer that advances after each access and clears on device reset.
// R15: Each enabled pattern matches when the crc16 over masked bytes from its offset equals the stored crc16.
// R16: A remote wake packet is six bytes of all ones then sixteen copies of the station address.
package wkd_pkg;
  ////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] WKD_ADDR_CTRL = 8'h68;
  localparam logic [7:0] WKD_ADDR_PATTERN_PORT = 8'h70;
  localparam logic [31:0] WKD_CTRL_WMASK = 32'h7E03_0700;
  localparam logic [31:0] WKD_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] WKD_CRC_WORD_MASK = 32'hFFFF_00FF;
  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int WKD_B_CRC_SEED = 30;
  localparam int WKD_B_PAT_ONE = 29;
  localparam int WKD_B_LINK_DOWN = 17;
  localparam int WKD_B_LINK_UP = 16;
  localparam int WKD_B_WFRAME_EN = 10;
  localparam int WKD_B_RWAKE_EN = 9;
  localparam int WKD_B_LCHG_EN = 8;
  localparam int WKD_B_WFRAME = 2;
  localparam int WKD_B_RWAKE = 1;
  localparam int WKD_B_LCHG = 0;
  ////////////////////////////////////////////////////////////////////////
  // pattern store and detectors
  localparam int WKD_PAT_NUM = 5;
  localparam int WKD_PAT_WORDS = 5;
  localparam int WKD_STORE_WORDS = 25;
  localparam int WKD_CRC_WORD = 4;
  localparam logic [15:0] WKD_CRC_SEED_ZERO = 16'h0000;
  localparam logic [15:0] WKD_CRC_SEED_ONE = 16'hFFFF;
  localparam logic [15:0] WKD_CRC_POLY = 16'h8005;
  localparam logic [7:0] WKD_SYNC_BYTE = 8'hFF;
  localparam logic [2:0] WKD_SYNC_COUNT = 3'h6;
  localparam logic [2:0] WKD_ADDR_LAST = 3'h5;
  localparam logic [3:0] WKD_REP_LAST = 4'hF;
  ////////////////////////////////////////////////////////////////////////
  // state encodings
  typedef enum logic [1:0] {
    WKD_BUS_IDLE = 2'b01,
    WKD_BUS_DONE = 2'b10
  } wkd_bus_st_t;
  typedef enum logic [1:0] {
    WKD_RW_HUNT = 2'b01,
    WKD_RW_ADDR = 2'b10
  } wkd_rw_st_t;
endpackage

// [rtl/wkd_remote_wake_det.sv]
module wkd_remote_wake_det
  import wkd_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic [7:0] rx_data,
  input wire logic [47:0] station_addr,
  output logic found
);
  wkd_rw_st_t st_r, st_nxt;
  logic [2:0] ff_r, ff_nxt;
  logic [2:0] bidx_r, bidx_nxt;
  logic [3:0] rep_r, rep_nxt;
  logic found_r, found_nxt;
  logic [7:0] want;
  logic [2:0] ff_in;
  wkd_rw_st_t st_in;

  // hunt for the sync run, then walk the address copies
  always_comb begin
    st_in = rx_sof ? WKD_RW_HUNT : st_r;
    ff_in = rx_sof ? 3'h0 : ff_r;
    want = station_addr[8'(6'd47 - {bidx_r, 3'h0}) -: 8];
    st_nxt = st_r;
    ff_nxt = ff_r;
    bidx_nxt = bidx_r;
    rep_nxt = rep_r;
    found_nxt = 1'b0;
    if (rx_valid) begin
      st_nxt = st_in;
      ff_nxt = ff_in;
      case (st_in)
        WKD_RW_HUNT: begin
          bidx_nxt = 3'h0;
          rep_nxt = 4'h0;
          if (rx_data == WKD_SYNC_BYTE) begin
            ff_nxt = (ff_in == WKD_SYNC_COUNT) ? ff_in : ff_in + 3'h1;
          end else begin
            ff_nxt = 3'h0;
          end
          if (ff_nxt == WKD_SYNC_COUNT) begin
            st_nxt = WKD_RW_ADDR;
          end
        end
        WKD_RW_ADDR: begin
          if (rx_data == (rx_sof ? station_addr[47:40] : want)) begin
            bidx_nxt = (bidx_r == WKD_ADDR_LAST) ? 3'h0 : bidx_r + 3'h1;
            if (bidx_r == WKD_ADDR_LAST) begin
              rep_nxt = rep_r + 4'h1;
              if (rep_r == WKD_REP_LAST) begin
                found_nxt = 1'b1; // [R16]
                st_nxt = WKD_RW_HUNT;
                ff_nxt = 3'h0;
              end
            end
          end else if (rx_data == WKD_SYNC_BYTE && bidx_r == 3'h0 && rep_r == 4'h0) begin
            st_nxt = WKD_RW_ADDR; // longer sync run
          end else begin
            st_nxt = WKD_RW_HUNT;
            ff_nxt = (rx_data == WKD_SYNC_BYTE) ? 3'h1 : 3'h0;
            bidx_nxt = 3'h0;
            rep_nxt = 4'h0;
          end
        end
        default: begin
          st_nxt = WKD_RW_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= WKD_RW_HUNT;
      ff_r <= 3'h0;
      bidx_r <= 3'h0;
      rep_r <= 4'h0;
      found_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ff_r <= ff_nxt;
      bidx_r <= bidx_nxt;
      rep_r <= rep_nxt;
      found_r <= found_nxt;
    end
  end

  assign found = found_r;
endmodule

// [rtl/wkd_wake_event_detector.sv]
module wkd_wake_event_detector
  import wkd_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic por,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic link_up,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic [7:0] rx_data,
  input wire logic [47:0] station_addr,
  input wire logic pm_enable,
  input wire logic wol_enable,
  output logic pm_event_status
);
  ////////////////////////////////////////////////////////////////////////
  // state
  wkd_bus_st_t bus_r, bus_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [2:0] flags_r, flags_nxt;
  logic pm_evt_r, pm_evt_nxt;
  logic link_prev_r, link_prev_nxt;
  logic [4:0] ptr_r, ptr_nxt;
  logic [31:0] store_r [WKD_STORE_WORDS];
  logic [31:0] store_nxt [WKD_STORE_WORDS];

  logic [31:0] be_mask;
  logic hit_ctrl;
  logic hit_port;
  logic do_write;
  logic do_access;
  logic [4:0] pat_match;
  logic [4:0] pat_en;
  logic rwake_found;
  logic ev_wframe;
  logic ev_lchg;
  logic [2:0] clr;
  logic [2:0] set;
  logic [31:0] ctrl_view;

  ////////////////////////////////////////////////////////////////////////
  // address decode and byte lanes
  always_comb begin
    hit_ctrl = 1'b0;
    hit_port = 1'b0;
    if (avs_address == WKD_ADDR_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (avs_address == WKD_ADDR_PATTERN_PORT) begin
      hit_port = 1'b1;
    end
    be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    do_access = (bus_r == WKD_BUS_DONE) && (avs_read || avs_write);
    do_write = do_access && avs_write;
  end

  // control view with the sticky flags in the low bits
  assign ctrl_view = {ctrl_r[31:3], flags_r};

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: answer one cycle after the request, act on completion
  always_comb begin
    bus_nxt = bus_r;
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    case (bus_r)
      WKD_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_nxt = WKD_BUS_DONE;
          wait_nxt = 1'b0;
          if (avs_read) begin
            if (hit_ctrl) begin
              rdata_nxt = ctrl_view;
            end else if (hit_port) begin
              rdata_nxt = store_r[ptr_r]; // [R13]
            end else begin
              rdata_nxt = 32'h0000_0000;
            end
          end
        end
      end
      WKD_BUS_DONE: begin
        bus_nxt = WKD_BUS_IDLE;
      end
      default: begin
        bus_nxt = WKD_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_r <= WKD_BUS_IDLE;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      bus_r <= bus_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register; remote wake enable resets from the pm and wol straps
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (do_write && hit_ctrl) begin
      ctrl_nxt = (ctrl_r & ~(be_mask & WKD_CTRL_WMASK)) |
                 (avs_writedata & be_mask & WKD_CTRL_WMASK);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_r <= WKD_CTRL_RESET;
      ctrl_r[WKD_B_RWAKE_EN] <= pm_enable && wol_enable; // [R6]
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pattern store behind the data port with its walking pointer
  always_comb begin
    store_nxt = store_r;
    ptr_nxt = ptr_r;
    if (do_access && hit_port) begin
      if (avs_write) begin
        if (ptr_r == 5'(WKD_CRC_WORD) || ptr_r == 5'(WKD_CRC_WORD + WKD_PAT_WORDS) ||
            ptr_r == 5'(WKD_CRC_WORD + 2 * WKD_PAT_WORDS) ||
            ptr_r == 5'(WKD_CRC_WORD + 3 * WKD_PAT_WORDS) ||
            ptr_r == 5'(WKD_CRC_WORD + 4 * WKD_PAT_WORDS)) begin
          store_nxt[ptr_r] = ((store_r[ptr_r] & ~be_mask) |
                              (avs_writedata & be_mask)) & WKD_CRC_WORD_MASK; // [R13]
        end else begin
          store_nxt[ptr_r] = (store_r[ptr_r] & ~be_mask) | (avs_writedata & be_mask);
        end
      end
      ptr_nxt = (ptr_r == 5'(WKD_STORE_WORDS - 1)) ? 5'h00 : ptr_r + 5'h01; // [R14]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ptr_r <= 5'h00; // [R14]
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // pattern contents are data, not control: no reset
  always_ff @(posedge core_clk) begin
    store_r <= store_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // one crc matcher per pattern
  for (genvar p = 0; p < WKD_PAT_NUM; p++) begin : g_pat
    wkd_pattern_crc u_crc (
      .core_clk(core_clk),
      .srst(srst),
      .rx_valid(rx_valid),
      .rx_sof(rx_sof),
      .rx_eof(rx_eof),
      .rx_data(rx_data),
      .seed_one(ctrl_r[WKD_B_CRC_SEED]), // [R1]
      .mask({store_r[p * WKD_PAT_WORDS + 3], store_r[p * WKD_PAT_WORDS + 2],
             store_r[p * WKD_PAT_WORDS + 1], store_r[p * WKD_PAT_WORDS]}),
      .crc_ref(store_r[p * WKD_PAT_WORDS + WKD_CRC_WORD][31:16]),
      .offset(store_r[p * WKD_PAT_WORDS + WKD_CRC_WORD][7:0]),
      .match(pat_match[p])
    );
    assign pat_en[p] = ctrl_r[WKD_B_PAT_ONE - p]; // [R2]
  end

  // remote wake packet finder
  wkd_remote_wake_det u_rwake (
    .core_clk(core_clk),
    .srst(srst),
    .rx_valid(rx_valid),
    .rx_sof(rx_sof),
    .rx_data(rx_data),
    .station_addr(station_addr),
    .found(rwake_found)
  );

  ////////////////////////////////////////////////////////////////////////
  // wake events
  always_comb begin
    ev_wframe = |(pat_match & pat_en); // [R2]
    ev_lchg = (ctrl_r[WKD_B_LINK_DOWN] && link_prev_r && !link_up) || // [R3]
              (ctrl_r[WKD_B_LINK_UP] && !link_prev_r && link_up); // [R4]
    link_prev_nxt = link_up;
  end

  // link history follows the pin from device reset on, so no false edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      link_prev_r <= link_up;
    end else begin
      link_prev_r <= link_prev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky flags: write one to clear, a same-cycle event wins
  always_comb begin
    set = 3'h0;
    set[WKD_B_WFRAME] = ev_wframe; // [R8]
    set[WKD_B_RWAKE] = rwake_found; // [R9]
    set[WKD_B_LCHG] = ev_lchg; // [R10]
    clr = 3'h0;
    if (do_write && hit_ctrl && avs_byteenable[0]) begin
      clr = avs_writedata[2:0]; // [R11]
    end
    flags_nxt = (flags_r & ~clr) | set; // [R11]
    pm_evt_nxt = (flags_nxt[WKD_B_WFRAME] && ctrl_r[WKD_B_WFRAME_EN]) || // [R5]
                 (flags_nxt[WKD_B_RWAKE] && ctrl_r[WKD_B_RWAKE_EN]) || // [R6]
                 (flags_nxt[WKD_B_LCHG] && ctrl_r[WKD_B_LCHG_EN]); // [R7]
  end

  // only power-up reset touches these; device reset does not
  always_ff @(posedge core_clk) begin
    if (por) begin
      flags_r <= 3'h0; // [R12]
      pm_evt_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt; // [R12]
      pm_evt_r <= pm_evt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign pm_event_status = pm_evt_r;
endmodule

// [test/wkd_rx_model.sv]
module wkd_rx_model (
  input wire logic core_clk,
  input wire logic slow,
  output logic link_up,
  output logic rx_valid,
  output logic rx_sof,
  output logic rx_eof,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle line at time zero
  initial begin
    link_up = 1'b1;
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_data = 8'h5A;
  end
  // link status step
  task automatic set_link(input logic v);
    @(posedge core_clk);
    link_up <= v;
  endtask
  // one frame, one byte a cycle, random stalls when slow
  task automatic send(input logic [7:0] f[$]);
    int i;
    i = 0;
    while (i < f.size()) begin
      @(posedge core_clk);
      if (slow && $urandom_range(1, 0) == 1) begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end else begin
        rx_valid <= 1'b1;
        rx_sof <= (i == 0);
        rx_eof <= (i == f.size() - 1);
        rx_data <= f[i];
        i++;
      end
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    rx_eof <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule

// [test/wkd_sva.sv]
module wkd_sva
  import wkd_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic por,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic link_up,
  input wire logic pm_enable,
  input wire logic wol_enable,
  input wire logic pm_event_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sh_r, sh_nxt;
  logic seen_r, seen_nxt;
  ////////////////////////////////////////////////////////////////////////
  // shadow of control bits from accepted writes
  always_comb begin
    sh_nxt = sh_r;
    seen_nxt = seen_r | por;
    if (srst) begin
      sh_nxt = WKD_CTRL_RESET;
      sh_nxt[WKD_B_RWAKE_EN] = pm_enable & wol_enable;
    end else if (avs_write && !avs_waitrequest && avs_address == WKD_ADDR_CTRL) begin
      for (int k = 0; k < 4; k++) begin
        if (avs_byteenable[k]) begin
          sh_nxt[8*k+:8] = avs_writedata[8*k+:8] & WKD_CTRL_WMASK[8*k+:8];
        end
      end
    end
  end
  // shadow registers
  always_ff @(posedge core_clk) begin
    sh_r <= sh_nxt;
    seen_r <= seen_nxt;
  end
  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:2] !avs_waitrequest) else $error("request not answered");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  a_ctrl_read: assert property (
    avs_read && !avs_waitrequest && avs_address == WKD_ADDR_CTRL
    |-> avs_readdata[31:3] == sh_r[31:3]) else $error("control readback wrong");
  a_link_down: assert property (
    seen_r && sh_r[WKD_B_LINK_DOWN] && sh_r[WKD_B_LCHG_EN] && $fell(link_up)
    |-> ##[1:2] pm_event_status) else $error("link down missed");
  a_link_up: assert property (
    seen_r && sh_r[WKD_B_LINK_UP] && sh_r[WKD_B_LCHG_EN] && $rose(link_up)
    |-> ##[1:2] pm_event_status) else $error("link up missed");
  a_por_clear: assert property (por |=> !pm_event_status)
    else $error("status kept over power-up reset");
  a_pm_quiet: assert property (
    seen_r && sh_r[10:8] == 3'h0 && $past(sh_r[10:8]) == 3'h0 |-> !pm_event_status)
    else $error("status raised with events disabled");
endmodule

bind wkd_wake_event_detector wkd_sva u_sva (
  .core_clk(core_clk), .srst(srst), .por(por), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .link_up(link_up), .pm_enable(pm_enable),
  .wol_enable(wol_enable), .pm_event_status(pm_event_status)
);

// [test/wkd_wake_event_detector_tb.sv]
module wkd_wake_event_detector_tb
  import wkd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic srst, por, avs_read, avs_write, pm_enable, wol_enable, slow;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [47:0] station_addr = 48'h0;
  logic [31:0] avs_readdata, q, e, d;
  logic avs_waitrequest, link_up, rx_valid, rx_sof, rx_eof, pm_event_status;
  logic [7:0] rx_data, o;
  logic [3:0] b;
  logic [15:0] s, c;
  logic [127:0] m;
  logic [7:0] f[$];
  logic [31:0] st[25];
  int failures = 0, n_checks = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////
  always #2.5 core_clk = ~core_clk;
  wkd_wake_event_detector DUT (
    .core_clk(core_clk), .srst(srst), .por(por), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_up(link_up), .rx_valid(rx_valid),
    .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data), .station_addr(station_addr),
    .pm_enable(pm_enable), .wol_enable(wol_enable), .pm_event_status(pm_event_status)
  );
  wkd_rx_model M (
    .core_clk(core_clk), .slow(slow), .link_up(link_up), .rx_valid(rx_valid),
    .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data)
  );
  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dw);
    avs_write <= w;
    avs_read <= ~w;
    avs_address <= a;
    avs_writedata <= dw;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  // read control word after the event pipeline settles
  task automatic rd_ctrl();
    repeat (2) @(posedge core_clk);
    bus(1'b0, WKD_ADDR_CTRL, 32'h0);
  endtask
  // expected control word after a lane-masked write
  function automatic logic [31:0] lanes(input logic [31:0] v, input logic [31:0] dw,
                                        input logic [3:0] be);
    for (int k = 0; k < 4; k++) begin
      if (be[k]) v[8*k+:8] = dw[8*k+:8] & WKD_CTRL_WMASK[8*k+:8];
    end
    return v;
  endfunction
  // msb-first crc16 over masked frame bytes
  function automatic logic [15:0] crc16(input logic [15:0] sd, input logic [127:0] mk,
                                        input int off);
    logic [15:0] r;
    r = sd;
    for (int i = 0; i < 128; i++) begin
      if (mk[i] && off + i < f.size()) begin
        for (int j = 7; j >= 0; j--) begin
          r = {r[14:0], 1'b0} ^ ((r[15] ^ f[off+i][j]) ? WKD_CRC_POLY : 16'h0000);
        end
      end
    end
    return r;
  endfunction
  // control word with seed, one pattern enable and wake frame enable
  function automatic logic [31:0] pctl(input int p, input int k);
    return (32'(p % 2) << WKD_B_CRC_SEED) | (32'h1 << (WKD_B_PAT_ONE - k)) |
           (32'h1 << WKD_B_WFRAME_EN);
  endfunction
  // remote wake frame with n address copies
  task automatic rw_frame(input int n);
    f = {};
    repeat (3) f.push_back(8'($urandom_range(254, 0)));
    repeat (6) f.push_back(WKD_SYNC_BYTE);
    repeat (n) for (int k = 5; k >= 0; k--) f.push_back(station_addr[8*k+:8]);
    f.push_back(8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h524A));
    srst <= 1'b1;
    por <= 1'b1;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    pm_enable <= 1'b1;
    wol_enable <= 1'b1;
    slow <= 1'b0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    por <= 1'b0;
    bus(1'b0, WKD_ADDR_CTRL, 32'h0);
    chk(q, 32'h0000_0200);
    e = 32'h0000_0200;
    repeat (6) begin
      d = $urandom;
      b = 4'($urandom);
      avs_byteenable <= b;
      bus(1'b1, WKD_ADDR_CTRL, d);
      e = lanes(e, d, b);
      avs_byteenable <= 4'hF;
      bus(1'b0, WKD_ADDR_CTRL, 32'h0);
      chk(q, e);
    end
    bus(1'b1, 8'h6C, $urandom);
    bus(1'b0, 8'h6C, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, WKD_ADDR_CTRL, 32'h0);
    chk(q, e);
    $display("test registers done");
    e = 32'h0003_0100;
    bus(1'b1, WKD_ADDR_CTRL, e | 32'h7);
    M.set_link(1'b0);
    rd_ctrl();
    chk(q, e | 32'h1);
    chk(32'(pm_event_status), 32'h1);
    bus(1'b1, WKD_ADDR_CTRL, e);
    rd_ctrl();
    chk(q, e | 32'h1);
    bus(1'b1, WKD_ADDR_CTRL, e | 32'h1);
    rd_ctrl();
    chk(q, e);
    chk(32'(pm_event_status), 32'h0);
    M.set_link(1'b1);
    rd_ctrl();
    chk(q, e | 32'h1);
    bus(1'b1, WKD_ADDR_CTRL, 32'h0000_0101);
    M.set_link(1'b0);
    M.set_link(1'b1);
    rd_ctrl();
    chk(q, 32'h0000_0100);
    bus(1'b1, WKD_ADDR_CTRL, 32'h0002_0100);
    M.set_link(1'b0);
    wol_enable <= 1'b0;
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd_ctrl();
    chk(q, 32'h0000_0001);
    por <= 1'b1;
    @(posedge core_clk);
    por <= 1'b0;
    rd_ctrl();
    chk(q, 32'h0);
    chk(32'(pm_event_status), 32'h0);
    M.set_link(1'b1);
    pm_enable <= 1'b0;
    wol_enable <= 1'b1;
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    rd_ctrl();
    chk(q, 32'h0);
    $display("test link done");
    station_addr <= {16'($urandom), $urandom};
    bus(1'b1, WKD_ADDR_CTRL, 32'h0000_0200);
    for (int n = 15; n < 17; n++) begin
      rw_frame(n);
      slow <= 1'($urandom);
      M.send(f);
      rd_ctrl();
      chk(q, (n == 16) ? 32'h0000_0202 : 32'h0000_0200);
    end
    chk(32'(pm_event_status), 32'h1);
    bus(1'b1, WKD_ADDR_CTRL, 32'h0);
    rd_ctrl();
    chk(32'(pm_event_status), 32'h0);
    bus(1'b1, WKD_ADDR_CTRL, 32'h7);
    $display("test remote wake done");
    for (int p = 0; p < 5; p++) begin
      f = {};
      repeat (40) f.push_back(8'($urandom));
      m = 128'($urandom);
      o = 8'($urandom_range(7, 0));
      s = (p % 2 == 1) ? WKD_CRC_SEED_ONE : WKD_CRC_SEED_ZERO;
      c = crc16(s, m, int'(o));
      for (int k = 0; k < 25; k++) begin
        st[k] = (k / 5 == p && k % 5 == 0) ? m[31:0] : 32'h0;
        if (k % 5 == 4) st[k] = (k / 5 == p) ? {c, 8'hA5, o} : {s ^ 16'h0001, 16'h0000};
        bus(1'b1, WKD_ADDR_PATTERN_PORT, st[k]);
      end
      for (int t = 0; t < 2; t++) begin
        e = pctl(p, (t == 0) ? (p + 1) % 5 : p);
        bus(1'b1, WKD_ADDR_CTRL, e);
        slow <= 1'($urandom);
        M.send(f);
        rd_ctrl();
        chk(q, (t == 0) ? e : (e | 32'h4));
      end
      chk(32'(pm_event_status), 32'h1);
      bus(1'b1, WKD_ADDR_CTRL, e | 32'h7);
    end
    for (int k = 0; k < 25; k++) begin
      bus(1'b0, WKD_ADDR_PATTERN_PORT, 32'h0);
      chk(q, (k % 5 == 4) ? (st[k] & WKD_CRC_WORD_MASK) : st[k]);
    end
    $display("test patterns done");
    end_sim();
  end
endmodule
